// ==== verilog/cels_pkg.sv ====
`default_nettype none
package cels_pkg;
  // ---------------------------------------------------------------
  // word and counter layout
  // ---------------------------------------------------------------
  localparam int unsigned CW    = 16;
  localparam int unsigned NCNT  = 3;
  localparam int unsigned C_UP  = 0;
  localparam int unsigned C_DN  = 1;
  localparam int unsigned C_UD  = 2;
  typedef logic [CW-1:0] cels_word_t;
  localparam cels_word_t  CV_ZERO = 16'h0000;
  localparam cels_word_t  CV_ONE  = 16'h0001;
  localparam cels_word_t  CV_MAX  = 16'hFFFF;
  // counter control vector {ld, clr, dn, up}
  localparam int unsigned CB_UP  = 0;
  localparam int unsigned CB_DN  = 1;
  localparam int unsigned CB_CLR = 2;
  localparam int unsigned CB_LD  = 3;
  localparam int unsigned CB_W   = 4;
  // ---------------------------------------------------------------
  // register fields
  // ---------------------------------------------------------------
  localparam int unsigned CT_RUN    = 0;
  localparam int unsigned CT_STEP   = 1;
  localparam int unsigned CT_W      = 2;
  localparam int unsigned IN_UP_CU  = 0;
  localparam int unsigned IN_UP_CLR = 1;
  localparam int unsigned IN_DN_CD  = 2;
  localparam int unsigned IN_DN_LD  = 3;
  localparam int unsigned IN_UD_CU  = 4;
  localparam int unsigned IN_UD_CD  = 5;
  localparam int unsigned IN_UD_CLR = 6;
  localparam int unsigned IN_UD_LD  = 7;
  localparam int unsigned IN_RISE   = 8;
  localparam int unsigned IN_FALL   = 9;
  localparam int unsigned IN_SET    = 10;
  localparam int unsigned IN_RST    = 11;
  localparam int unsigned IN_W      = 12;
  localparam int unsigned ST_W      = 7;
  // ---------------------------------------------------------------
  // bus and address map
  // ---------------------------------------------------------------
  localparam int unsigned AW     = 8;
  localparam int unsigned AL     = 2;
  localparam int unsigned DW     = 32;
  localparam int unsigned SW     = 4;
  localparam int unsigned BYTE_W = 8;
  localparam logic [AW-1:0] A_CTRL = 8'h00;
  localparam logic [AW-1:0] A_IN   = 8'h04;
  localparam logic [AW-1:0] A_PUP  = 8'h08;
  localparam logic [AW-1:0] A_PDN  = 8'h0C;
  localparam logic [AW-1:0] A_PUD  = 8'h10;
  localparam logic [AW-1:0] A_CUP  = 8'h14;
  localparam logic [AW-1:0] A_CDN  = 8'h18;
  localparam logic [AW-1:0] A_CUD  = 8'h1C;
  localparam logic [AW-1:0] A_ST   = 8'h20;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    RG_CTRL, RG_IN, RG_PUP, RG_PDN, RG_PUD, RG_CUP, RG_CDN, RG_CUD, RG_ST, RG_NONE
  } cels_reg_t;
  localparam cels_reg_t PRE_ID [NCNT] = '{RG_PUP, RG_PDN, RG_PUD};

  function automatic cels_reg_t cels_dec(input logic [AW-1:0] a);
    cels_reg_t r;
    r = RG_NONE;
    case (a[AW-1:AL])
      A_CTRL[AW-1:AL]: r = RG_CTRL;
      A_IN[AW-1:AL]:   r = RG_IN;
      A_PUP[AW-1:AL]:  r = RG_PUP;
      A_PDN[AW-1:AL]:  r = RG_PDN;
      A_PUD[AW-1:AL]:  r = RG_PUD;
      A_CUP[AW-1:AL]:  r = RG_CUP;
      A_CDN[AW-1:AL]:  r = RG_CDN;
      A_CUD[AW-1:AL]:  r = RG_CUD;
      A_ST[AW-1:AL]:   r = RG_ST;
      default:         r = RG_NONE;
    endcase
    return r;
  endfunction : cels_dec

  // counts stick at their limits instead of wrapping
  function automatic cels_word_t cels_inc(input cels_word_t v);
    return (v == CV_MAX) ? v : v + CV_ONE;
  endfunction : cels_inc

  function automatic cels_word_t cels_dec_cnt(input cels_word_t v);
    return (v == CV_ZERO) ? v : v - CV_ONE;
  endfunction : cels_dec_cnt
endpackage : cels_pkg
`default_nettype wire

// ==== verilog/cels_cnt_if.sv ====
`default_nettype none
interface cels_cnt_if;
  import cels_pkg::*;
  logic       eval;
  logic       up_lvl;
  logic       dn_lvl;
  logic       clr;
  logic       ld;
  cels_word_t preset;
  cels_word_t cv;
  logic       ge;
  logic       zero;
  modport ctl (output eval, up_lvl, dn_lvl, clr, ld, preset, input cv, ge, zero);
  modport cnt (input eval, up_lvl, dn_lvl, clr, ld, preset, output cv, ge, zero);
endinterface : cels_cnt_if
`default_nettype wire

// ==== verilog/cels_counter.sv ====
`default_nettype none
module cels_counter
  import cels_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control side
  cels_cnt_if.cnt  cif
);
  logic       up_prev_r;
  logic       dn_prev_r;
  logic       up_edge;
  logic       dn_edge;
  cels_word_t cv_r;
  cels_word_t cv_nxt;
  logic       ge_r;
  logic       zero_r;

  assign up_edge = cif.eval & cif.up_lvl & ~up_prev_r;
  assign dn_edge = cif.eval & cif.dn_lvl & ~dn_prev_r;
  // both edges in one scan cancel out
  assign cv_nxt = !cif.eval ? cv_r :
                  cif.clr ? CV_ZERO :
                  cif.ld ? cif.preset :
                  (up_edge & ~dn_edge) ? cels_inc(cv_r) :
                  (dn_edge & ~up_edge) ? cels_dec_cnt(cv_r) :
                  cv_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      up_prev_r <= 1'b0;
      dn_prev_r <= 1'b0;
      cv_r      <= CV_ZERO;
      ge_r      <= 1'b1;
      zero_r    <= 1'b1;
    end else begin
      if (cif.eval) begin
        up_prev_r <= cif.up_lvl;
        dn_prev_r <= cif.dn_lvl;
      end
      cv_r   <= cv_nxt;
      ge_r   <= (cv_nxt >= cif.preset);
      zero_r <= (cv_nxt == CV_ZERO);
    end
  end

  assign cif.cv   = cv_r;
  assign cif.ge   = ge_r;
  assign cif.zero = zero_r;
endmodule : cels_counter
`default_nettype wire

// ==== verilog/cels_bool.sv ====
`default_nettype none
module cels_bool
  import cels_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // scan inputs
  input  wire logic eval,
  input  wire logic rise_in,
  input  wire logic fall_in,
  input  wire logic set_in,
  input  wire logic rst_in,
  // results
  output logic      rise_q,
  output logic      fall_q,
  output logic      latch_q
);
  logic rise_prev_r;
  logic fall_prev_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rise_prev_r <= 1'b0;
      fall_prev_r <= 1'b0;
      rise_q      <= 1'b0;
      fall_q      <= 1'b0;
      latch_q     <= 1'b0;
    end else if (eval) begin
      rise_prev_r <= rise_in;
      fall_prev_r <= fall_in;
      rise_q      <= rise_in & ~rise_prev_r;
      fall_q      <= ~fall_in & fall_prev_r;
      latch_q     <= set_in | (latch_q & ~rst_in);
    end
  end
endmodule : cels_bool
`default_nettype wire

// ==== verilog/cels_top.sv ====
`default_nettype none
module cels_top
  import cels_pkg::*;
(
  // clock and reset
  input  wire logic          clock,
  input  wire logic          rst_n,
  // write address
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  // write data
  input  wire logic [DW-1:0] s_axi_wdata,
  input  wire logic [SW-1:0] s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  // write response
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // read address
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  // read data
  output logic [DW-1:0]      s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // primitive results
  output logic               up_done,
  output logic               dn_done,
  output logic               ud_upper,
  output logic               ud_zero,
  output logic               rise_pulse,
  output logic               fall_pulse,
  output logic               latch_out,
  output cels_word_t         up_count,
  output cels_word_t         dn_count,
  output cels_word_t         ud_count
);
  // ---------------------------------------------------------------
  // write channel capture
  // ---------------------------------------------------------------
  logic            aw_got_r;
  logic [AW-1:0]   aw_addr_r;
  logic            w_got_r;
  logic [DW-1:0]   w_data_r;
  logic [SW-1:0]   w_strb_r;
  logic            bvalid_r;
  logic [1:0]      bresp_r;
  logic            aw_hs;
  logic            w_hs;
  logic            wr_fire;
  cels_reg_t       wr_reg;
  logic [DW-1:0]   wmask;

  assign s_axi_awready = ~aw_got_r & ~bvalid_r;
  assign s_axi_wready  = ~w_got_r & ~bvalid_r;
  assign aw_hs         = s_axi_awvalid & s_axi_awready;
  assign w_hs          = s_axi_wvalid & s_axi_wready;
  assign wr_fire       = aw_got_r & w_got_r & ~bvalid_r;
  assign wr_reg        = cels_dec(aw_addr_r);
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  for (genvar b = 0; b < SW; b++) begin : g_mask
    assign wmask[b*BYTE_W +: BYTE_W] = {BYTE_W{w_strb_r[b]}};
  end

  function automatic logic [DW-1:0] wmerge(input logic [DW-1:0] old,
                                           input logic [DW-1:0] d,
                                           input logic [DW-1:0] m);
    return (old & ~m) | (d & m);
  endfunction : wmerge

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aw_got_r  <= 1'b0;
      aw_addr_r <= A_CTRL;
      w_got_r   <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_got_r  <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= (wr_reg == RG_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // control, inputs and presets
  // ---------------------------------------------------------------
  logic            run_r;
  logic            step_r;
  logic            eval;
  logic [IN_W-1:0] in_r;
  cels_word_t      pre_r [NCNT];
  logic [DW-1:0]   ctrl_wr;
  logic [DW-1:0]   in_wr;
  logic [DW-1:0]   pre_wr [NCNT];

  assign ctrl_wr = wmerge({{(DW-1){1'b0}}, run_r}, w_data_r, wmask);
  assign in_wr   = wmerge({{(DW-IN_W){1'b0}}, in_r}, w_data_r, wmask);
  // one scan per cycle while running, or one scan per step write
  assign eval    = run_r | step_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      run_r  <= 1'b0;
      step_r <= 1'b0;
      in_r   <= '0;
    end else begin
      step_r <= wr_fire && (wr_reg == RG_CTRL) && ctrl_wr[CT_STEP];
      if (wr_fire && (wr_reg == RG_CTRL)) begin
        run_r <= ctrl_wr[CT_RUN];
      end
      if (wr_fire && (wr_reg == RG_IN)) begin
        in_r <= in_wr[IN_W-1:0];
      end
    end
  end

  for (genvar i = 0; i < NCNT; i++) begin : g_pre
    assign pre_wr[i] = wmerge({{(DW-CW){1'b0}}, pre_r[i]}, w_data_r, wmask);
    always_ff @(posedge clock) begin
      if (!rst_n) begin
        pre_r[i] <= CV_ZERO;
      end else if (wr_fire && (wr_reg == PRE_ID[i])) begin
        pre_r[i] <= pre_wr[i][CW-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // primitives
  // ---------------------------------------------------------------
  cels_cnt_if      cif [NCNT] ();
  logic [CB_W-1:0] cin [NCNT];

  // absent controls tie low: the up counter has no load, the down no clear
  assign cin[C_UP] = {1'b0, in_r[IN_UP_CLR], 1'b0, in_r[IN_UP_CU]};
  assign cin[C_DN] = {in_r[IN_DN_LD], 1'b0, in_r[IN_DN_CD], 1'b0};
  assign cin[C_UD] = {in_r[IN_UD_LD], in_r[IN_UD_CLR], in_r[IN_UD_CD], in_r[IN_UD_CU]};

  for (genvar i = 0; i < NCNT; i++) begin : g_cnt
    assign cif[i].eval   = eval;
    assign cif[i].up_lvl = cin[i][CB_UP];
    assign cif[i].dn_lvl = cin[i][CB_DN];
    assign cif[i].clr    = cin[i][CB_CLR];
    assign cif[i].ld     = cin[i][CB_LD];
    assign cif[i].preset = pre_r[i];
    cels_counter u_cnt (
      .clock (clock),
      .rst_n (rst_n),
      .cif   (cif[i])
    );
  end

  cels_bool u_bool (
    .clock   (clock),
    .rst_n   (rst_n),
    .eval    (eval),
    .rise_in (in_r[IN_RISE]),
    .fall_in (in_r[IN_FALL]),
    .set_in  (in_r[IN_SET]),
    .rst_in  (in_r[IN_RST]),
    .rise_q  (rise_pulse),
    .fall_q  (fall_pulse),
    .latch_q (latch_out)
  );

  assign up_count = cif[C_UP].cv;
  assign dn_count = cif[C_DN].cv;
  assign ud_count = cif[C_UD].cv;
  assign up_done  = cif[C_UP].ge;
  assign dn_done  = cif[C_DN].zero;
  assign ud_upper = cif[C_UD].ge;
  assign ud_zero  = cif[C_UD].zero;

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  cels_reg_t       rd_reg;
  logic [DW-1:0]   rd_word;
  logic [ST_W-1:0] status;
  logic            rvalid_r;
  logic [DW-1:0]   rdata_r;
  logic [1:0]      rresp_r;

  assign rd_reg  = cels_dec(s_axi_araddr);
  assign status  = {latch_out, fall_pulse, rise_pulse, ud_zero, ud_upper, dn_done, up_done};
  // the step bit always reads back as zero
  assign rd_word = (rd_reg == RG_CTRL) ? {{(DW-1){1'b0}}, run_r} :
                   (rd_reg == RG_IN)   ? {{(DW-IN_W){1'b0}}, in_r} :
                   (rd_reg == RG_PUP)  ? {{(DW-CW){1'b0}}, pre_r[C_UP]} :
                   (rd_reg == RG_PDN)  ? {{(DW-CW){1'b0}}, pre_r[C_DN]} :
                   (rd_reg == RG_PUD)  ? {{(DW-CW){1'b0}}, pre_r[C_UD]} :
                   (rd_reg == RG_CUP)  ? {{(DW-CW){1'b0}}, up_count} :
                   (rd_reg == RG_CDN)  ? {{(DW-CW){1'b0}}, dn_count} :
                   (rd_reg == RG_CUD)  ? {{(DW-CW){1'b0}}, ud_count} :
                   (rd_reg == RG_ST)   ? {{(DW-ST_W){1'b0}}, status} :
                   32'h0000_0000;

  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_word;
      rresp_r  <= (rd_reg == RG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [IN_W-1:0] seen_r;
  logic [IN_W-1:0] redg;
  logic [IN_W-1:0] fedg;
  cels_word_t      pre_up;
  cels_word_t      pre_dn;
  cels_word_t      pre_ud;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      seen_r <= '0;
    end else if (eval) begin
      seen_r <= in_r;
    end
  end
  assign redg   = in_r & ~seen_r;
  assign fedg   = seen_r & ~in_r;
  assign pre_up = pre_r[C_UP];
  assign pre_dn = pre_r[C_DN];
  assign pre_ud = pre_r[C_UD];

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence up_rise_s;
    eval && redg[IN_UP_CU] && !in_r[IN_UP_CLR];
  endsequence
  sequence dn_rise_s;
    eval && redg[IN_DN_CD] && !in_r[IN_DN_LD];
  endsequence
  sequence ud_free_s;
    eval && !in_r[IN_UD_CLR] && !in_r[IN_UD_LD];
  endsequence

  up_count_inc_a: assert property (up_rise_s |=> up_count == cels_inc($past(up_count)))
    else $error("up count did not step up");
  up_clear_a: assert property (eval && in_r[IN_UP_CLR] |=> up_count == CV_ZERO)
    else $error("up count not cleared");
  ud_clear_a: assert property (eval && in_r[IN_UD_CLR] |=> ud_count == CV_ZERO && ud_zero)
    else $error("up-down count not cleared");
  up_done_flag_a: assert property (up_done == (up_count >= $past(pre_up)))
    else $error("up done flag wrong");
  dn_count_dec_a: assert property (dn_rise_s |=> dn_count == cels_dec_cnt($past(dn_count)))
    else $error("down count did not step down");
  dn_load_a: assert property (eval && in_r[IN_DN_LD] |=> dn_count == $past(pre_dn))
    else $error("down count not loaded");
  zero_flags_a: assert property ((dn_done == (dn_count == CV_ZERO)) && (ud_zero == (ud_count == CV_ZERO)))
    else $error("zero flag wrong");
  ud_step_up_a: assert property (ud_free_s ##0 (redg[IN_UD_CU] && !redg[IN_UD_CD])
                                 |=> ud_count == cels_inc($past(ud_count)))
    else $error("up-down count did not step up");
  ud_step_dn_a: assert property (ud_free_s ##0 (redg[IN_UD_CD] && !redg[IN_UD_CU])
                                 |=> ud_count == cels_dec_cnt($past(ud_count)))
    else $error("up-down count did not step down");
  ud_cancel_a: assert property (ud_free_s ##0 (redg[IN_UD_CU] && redg[IN_UD_CD]) |=> $stable(ud_count))
    else $error("opposite edges did not cancel");
  ud_upper_flag_a: assert property (ud_upper == (ud_count >= $past(pre_ud)))
    else $error("upper flag wrong");
  count_idle_a: assert property (!eval |=> $stable(up_count) && $stable(dn_count) && $stable(ud_count))
    else $error("count moved without a scan");
  rise_pulse_a: assert property (eval && redg[IN_RISE] |=> rise_pulse)
    else $error("rising pulse missing");
  rise_drop_a: assert property (eval && !redg[IN_RISE] |=> !rise_pulse)
    else $error("rising pulse too long");
  fall_pulse_a: assert property (eval && fedg[IN_FALL] |=> fall_pulse)
    else $error("falling pulse missing");
  fall_drop_a: assert property (eval && !fedg[IN_FALL] |=> !fall_pulse)
    else $error("falling pulse too long");
  latch_set_a: assert property (eval && in_r[IN_SET] |=> latch_out)
    else $error("latch not set");
  latch_hold_a: assert property (eval && !in_r[IN_SET] && !in_r[IN_RST] |=> $stable(latch_out))
    else $error("latch did not hold");
  latch_clear_a: assert property (eval && !in_r[IN_SET] && in_r[IN_RST] |=> !latch_out)
    else $error("latch not cleared");
  latch_both_a: assert property (eval && in_r[IN_SET] && in_r[IN_RST] |=> latch_out)
    else $error("set did not win");
  scan_only_a: assert property (!eval |=> $stable(rise_pulse) && $stable(fall_pulse) && $stable(latch_out))
    else $error("primitive moved without a scan");
  step_scan_a: assert property (wr_fire && wr_reg == RG_CTRL && ctrl_wr[CT_STEP] |=> eval)
    else $error("step write gave no scan");
  ud_load_a: assert property (eval && !in_r[IN_UD_CLR] && in_r[IN_UD_LD] |=> ud_count == $past(pre_ud))
    else $error("load did not beat edges");
  ud_clr_first_a: assert property (eval && in_r[IN_UD_CLR] && in_r[IN_UD_LD] |=> ud_count == CV_ZERO)
    else $error("clear did not beat load");
  sat_top_a: assert property (up_rise_s ##0 (up_count == CV_MAX) |=> up_count == CV_MAX)
    else $error("up count wrapped");
  ud_sat_top_a: assert property (ud_free_s ##0 (redg[IN_UD_CU] && !redg[IN_UD_CD] && ud_count == CV_MAX)
                                 |=> ud_count == CV_MAX)
    else $error("up-down count wrapped");
  sat_bottom_a: assert property (dn_rise_s ##0 (dn_count == CV_ZERO) |=> dn_count == CV_ZERO)
    else $error("down count wrapped");
endmodule : cels_top
`default_nettype wire

// ==== bench/cels_host.sv ====
`default_nettype none
// -------------------------------------------
// control-side master: one transfer at a time
// -------------------------------------------
module cels_host
  import cels_pkg::*;
(
  // clock
  input  wire logic         clock,
  // write side
  output var logic [AW-1:0] s_axi_awaddr,
  output var logic          s_axi_awvalid,
  input  wire logic         s_axi_awready,
  output var logic [DW-1:0] s_axi_wdata,
  output var logic [SW-1:0] s_axi_wstrb,
  output var logic          s_axi_wvalid,
  input  wire logic         s_axi_wready,
  input  wire logic [1:0]   s_axi_bresp,
  input  wire logic         s_axi_bvalid,
  output var logic          s_axi_bready,
  // read side
  output var logic [AW-1:0] s_axi_araddr,
  output var logic          s_axi_arvalid,
  input  wire logic         s_axi_arready,
  input  wire logic [DW-1:0] s_axi_rdata,
  input  wire logic [1:0]   s_axi_rresp,
  input  wire logic         s_axi_rvalid,
  output var logic          s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // handshakes are judged at the falling edge so the rising edge never races
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d, output logic [1:0] r);
    logic pa, pw, ha, hw;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(negedge clock);
      ha = pa && s_axi_awready;
      hw = pw && s_axi_wready;
      @(posedge clock);
      if (ha) s_axi_awvalid <= 1'b0;
      if (ha) s_axi_awaddr <= ~a;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hw) s_axi_wdata <= ~d;
      pa = pa && !ha;
      pw = pw && !hw;
    end
    do @(negedge clock); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge clock);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clock); while (!s_axi_arready);
    @(posedge clock);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(negedge clock); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clock);
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : cels_host
`default_nettype wire

// ==== bench/testbench.sv ====
`default_nettype none
module testbench
  import cels_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DW-1:0] s_axi_wdata, s_axi_rdata, d;
  logic [SW-1:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic up_done, dn_done, ud_upper, ud_zero, rise_pulse, fall_pulse, latch_out, rq, fq, lq;
  cels_word_t up_count, dn_count, ud_count;
  logic [IN_W-1:0] in, pin;
  int miscompares = 0;
  int n_tests = 0;
  int up, dn, ud, pu, pd, pud;
  always #20 clock = ~clock;
  cels_top cels_top_i (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .up_done,
    .dn_done, .ud_upper, .ud_zero, .rise_pulse, .fall_pulse, .latch_out, .up_count, .dn_count, .ud_count);
  cels_host cels_host_i (.clock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  function automatic int sat(input int v);
    return v < 0 ? 0 : (v > 65535 ? 65535 : v);
  endfunction : sat
  function automatic int pv();
    return ($urandom_range(7) == 0) ? 65535 : $urandom_range(4);
  endfunction : pv
  // --------------------------------
  // reference model: one scan
  // --------------------------------
  task automatic scan();
    logic eu, ed;
    eu = in[IN_UD_CU] && !pin[IN_UD_CU];
    ed = in[IN_UD_CD] && !pin[IN_UD_CD];
    if (in[IN_UP_CLR]) up = 0;
    else if (in[IN_UP_CU] && !pin[IN_UP_CU]) up = sat(up + 1);
    if (in[IN_DN_LD]) dn = pd;
    else if (in[IN_DN_CD] && !pin[IN_DN_CD]) dn = sat(dn - 1);
    if (in[IN_UD_CLR]) ud = 0;
    else if (in[IN_UD_LD]) ud = pud;
    else if (eu != ed) ud = sat(eu ? ud + 1 : ud - 1);
    rq = in[IN_RISE] && !pin[IN_RISE];
    fq = !in[IN_FALL] && pin[IN_FALL];
    lq = in[IN_SET] || (lq && !in[IN_RST]);
    pin = in;
  endtask : scan
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic check_all();
    chk({up_count, dn_count}, {16'(up), 16'(dn)});
    chk(32'(ud_count), 32'(ud));
    chk(32'({up_done, dn_done, ud_upper, ud_zero}), 32'({up >= pu, dn == 0, ud >= pud, ud == 0}));
    chk(32'({rise_pulse, fall_pulse, latch_out}), 32'({rq, fq, lq}));
  endtask : check_all
  task automatic report_and_stop();
    if (miscompares == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (50000) @(posedge clock);
    miscompares++;
    report_and_stop();
  end
  initial begin
    {up, dn, ud, pu, pd, pud, rq, fq, lq, pin} = '0;
    void'($urandom(32'ha74f_bc3f));
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    cels_host_i.wr(A_CUP, 32'h0000_1234, r);
    chk(32'(r), 32'(RESP_OKAY));
    cels_host_i.rd(8'h24, d, r);
    chk(d, 32'h0000_0000);
    chk(32'(r), 32'(RESP_SLVERR));
    @(negedge clock);
    check_all();
    // clear and load bits are thinned so counts get room to move
    for (int i = 0; i < 300; i++) begin
      if ($urandom_range(3) == 0) begin
        pu = pv();
        pd = pv();
        pud = pv();
        cels_host_i.wr(A_PUP, 32'(pu), r);
        cels_host_i.wr(A_PDN, 32'(pd), r);
        cels_host_i.wr(A_PUD, 32'(pud), r);
      end
      in = IN_W'($urandom & (($urandom_range(3) == 0) ? 32'h0000_0fff : 32'h0000_0f35));
      cels_host_i.wr(A_IN, 32'(in), r);
      chk(32'(r), 32'(RESP_OKAY));
      // a run burst scans many times and settles where two scans would
      if ($urandom_range(3) == 1) begin
        cels_host_i.wr(A_CTRL, 32'h0000_0001, r);
        cels_host_i.wr(A_CTRL, 32'h0000_0000, r);
        scan();
      end else begin
        cels_host_i.wr(A_CTRL, 32'h0000_0002, r);
      end
      scan();
      repeat (2) @(negedge clock);
      check_all();
      cels_host_i.rd(A_ST, d, r);
      chk(d, 32'({lq, fq, rq, ud == 0, ud >= pud, dn == 0, up >= pu}));
      cels_host_i.rd(A_CUD, d, r);
      chk(d, 32'(ud));
    end
    // reset while stopped after the last scan clears counts, presets, inputs and the latch
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    {up, dn, ud, pu, pd, pud, rq, fq, lq, pin, in} = '0;
    @(negedge clock);
    check_all();
    cels_host_i.rd(A_IN, d, r);
    chk(d, 32'h0000_0000);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
